//--- verilog/cfgld_serial_loader.sv
/*
  cfgld_serial_loader: mode decoder and bit-serial configuration port.
  Assumes mode pins, config clock and serial data arrive asynchronously to
  ref_clk and are synchronised here; the config clock is far slower than ref_clk.
*/
`timescale 1ns/1ps

// Operation
// - decode mode pins to mode and pull-up choice
// - codes 111 or 011 select serial slave
// - codes 000 or 100 select serial master
// - codes 101 or 001 select boundary scan
// - boundary scan selected disables other modes
// - floating mode pins read high, slave default
// - data bit sampled on config clock rise
// - after own bits, forward data down chain
// - chain output changes on rising clock edge
// - master drives clock from internal oscillator
// - master starts at 2.5 MHz until rate loaded
// - loaded rate never lowers current clock
// - highest selectable rate is 60 MHz
// - default rate setting is 4 MHz
// - init resets PROM, completion enables PROM
// - completion driven high only with active drive option
// - init rises after clear, completion after load
module cfgld_serial_loader
  import cfgld_pkg::*;
#(
  parameter int OWN_BITS = 64                  // length of this device's own bitstream
) (
  input  wire logic        ref_clk,            // system clock, 200 MHz
  input  wire logic        reset_n,            // async reset, active low
  input  wire logic        clkEn,              // freezes all state while low
  input  wire logic        hsel,               // ahb slave select
  input  wire logic [31:0] haddr,              // ahb address
  input  wire logic [1:0]  htrans,             // ahb transfer type
  input  wire logic        hwrite,             // ahb write
  input  wire logic [2:0]  hsize,              // ahb size, word only
  input  wire logic [31:0] hwdata,             // ahb write data
  input  wire logic        hready,             // ahb bus ready
  output logic      [31:0] hrdata,             // ahb read data
  output logic             hreadyout,          // ahb slave ready
  output logic             hresp,              // ahb response, always okay
  input  wire logic [2:0]  modeSelectPins,     // mode pins MODE_SELECT_PINS
  input  wire logic        configClockIn,      // config_clock pin input
  output logic             configClockOut,     // config_clock pin output
  output logic             configClockOe,      // config_clock output enable
  input  wire logic        serialDataIn,       // serial configuration data
  output logic             serialChainOut,     // data for next chained device
  output logic             initStatusOut,      // init pin level driven
  output logic             initStatusOe,       // init pin open-drain enable
  output logic             completionOut,      // completion pin level driven
  output logic             completionOe,       // completion pin enable
  output logic             ioPullupEn,         // pull-ups on i/o before config
  output logic             bytePar,            // byte_parallel_mode selected
  output logic             boundaryScanSel     // boundary-scan mode selected
);

  // synchronisers: first stage read only by second
  logic [2:0] modeMeta_reg, modeSync_reg;
  logic       clkMeta_reg, clkSync_reg, clkPrev_reg;
  logic       dinMeta_reg, dinSync_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeMeta_reg <= MODE_PINS_DEFAULT;
      modeSync_reg <= MODE_PINS_DEFAULT;
      clkMeta_reg  <= 1'b0;
      clkSync_reg  <= 1'b0;
      clkPrev_reg  <= 1'b0;
      dinMeta_reg  <= 1'b0;
      dinSync_reg  <= 1'b0;
    end else if (clkEn) begin
      modeMeta_reg <= modeSelectPins;
      modeSync_reg <= modeMeta_reg;
      clkMeta_reg  <= configClockIn;
      clkSync_reg  <= clkMeta_reg;
      clkPrev_reg  <= clkSync_reg;
      dinMeta_reg  <= serialDataIn;
      dinSync_reg  <= dinMeta_reg;
    end
  end

  // mode decode: M1 M0 pick the mode, M2 xor (M1 or M0) chooses pull-ups
  cfgld_mode_t decMode;
  always_comb begin
    case (modeSync_reg[1:0])
      2'b00:   decMode = CFGLD_MODE_MASTER;
      2'b11:   decMode = CFGLD_MODE_SLAVE;
      2'b10:   decMode = CFGLD_MODE_BYTEPAR;
      2'b01:   decMode = CFGLD_MODE_BSCAN;
      default: decMode = CFGLD_MODE_SLAVE;
    endcase
  end

  // register state
  cfgld_state_t state_reg;
  cfgld_mode_t  mode_reg;
  logic         pullup_reg;
  logic         drive_reg;
  logic         programReq_reg;
  logic [15:0]  clearCnt_reg;
  logic [15:0]  bitCnt_reg;
  logic [2:0]   rateShift_reg;
  logic [2:0]   rateCode_reg;
  logic [7:0]   halfCnt_reg;
  logic [7:0]   halfLimit_reg;
  logic         config_clock_reg;
  logic         rateLoaded_reg;

  // ahb address phase capture
  logic        wrPend_reg;
  logic [7:0]  wrAddr_reg;
  logic        addrPhase;
  assign addrPhase = hsel && htrans[1] && hready;

  // one config_clock rise, either sampled from the pin or from our generator
  logic masterMode, cclkRise, genRise;
  assign masterMode = (mode_reg == CFGLD_MODE_MASTER);
  assign genRise    = !config_clock_reg && (halfCnt_reg == 8'h01);
  assign cclkRise   = masterMode ? genRise : (clkSync_reg && !clkPrev_reg);

  logic lastClear;
  assign lastClear = (clearCnt_reg == 16'(CLEAR_CYCLES - 1));

  // configuration sequence: clear, then mode latch, then serial load
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= CFGLD_ST_CLEAR;
      mode_reg     <= CFGLD_MODE_SLAVE;
      pullup_reg   <= 1'b0;
      clearCnt_reg <= 16'h0000;
    end else if (clkEn) begin
      if (programReq_reg) begin
        state_reg    <= CFGLD_ST_CLEAR;
        clearCnt_reg <= 16'h0000;
      end else begin
        case (state_reg)
          CFGLD_ST_CLEAR: begin
            clearCnt_reg <= clearCnt_reg + 16'h0001;
            mode_reg     <= decMode;
            pullup_reg   <= modeSync_reg[2] ^ (|modeSync_reg[1:0]);
            if (lastClear) begin
              // only serial modes load here; bscan turns them off
              state_reg <= (decMode == CFGLD_MODE_MASTER || decMode == CFGLD_MODE_SLAVE)
                           ? CFGLD_ST_LOAD : CFGLD_ST_HOLD;
            end
          end
          CFGLD_ST_LOAD: begin
            if (cclkRise && bitCnt_reg == 16'(OWN_BITS - 1)) begin
              state_reg <= CFGLD_ST_DONE;
            end
          end
          CFGLD_ST_DONE: state_reg <= CFGLD_ST_DONE;
          CFGLD_ST_HOLD: state_reg <= CFGLD_ST_HOLD;
          default:       state_reg <= CFGLD_ST_CLEAR;
        endcase
      end
    end
  end

  // own-bit counter and chain forwarding, both on config_clock rises
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_reg     <= 16'h0000;
      rateShift_reg  <= 3'h0;
      serialChainOut <= 1'b1;
    end else if (clkEn) begin
      if (state_reg == CFGLD_ST_CLEAR) begin
        bitCnt_reg    <= 16'h0000;
        rateShift_reg <= 3'h0;
      end else if (cclkRise && state_reg == CFGLD_ST_LOAD) begin
        bitCnt_reg    <= bitCnt_reg + 16'h0001;
        rateShift_reg <= {rateShift_reg[1:0], dinSync_reg};
      end else if (cclkRise && state_reg == CFGLD_ST_DONE) begin
        serialChainOut <= dinSync_reg;
      end
    end
  end

  // rate setting: power-up rate until the rate field is in, then only faster
  logic [7:0] newHalf;
  assign newHalf = half_cycles(RATE_MHZ10[rateShift_reg]);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      halfLimit_reg  <= POWERUP_HALF;
      rateCode_reg   <= 3'h0;
      rateLoaded_reg <= 1'b0;
    end else if (clkEn) begin
      if (state_reg == CFGLD_ST_CLEAR) begin
        halfLimit_reg  <= POWERUP_HALF;
        rateLoaded_reg <= 1'b0;
      end else if (!rateLoaded_reg && state_reg == CFGLD_ST_LOAD
                   && bitCnt_reg == 16'(RATE_POS + RATE_W)) begin
        rateLoaded_reg <= 1'b1;
        rateCode_reg   <= rateShift_reg;
        if (newHalf < halfLimit_reg) begin
          halfLimit_reg <= newHalf;
        end
      end
    end
  end

  // internal oscillator for master mode, divided from ref_clk
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      halfCnt_reg <= POWERUP_HALF;
      config_clock_reg    <= 1'b0;
    end else if (clkEn) begin
      if (!masterMode || (state_reg != CFGLD_ST_LOAD && state_reg != CFGLD_ST_DONE)) begin
        if (config_clock_reg && halfCnt_reg > 8'h01) begin
          // let a high phase run out: a cut one would be a runt pulse on the PROM clock
          halfCnt_reg <= halfCnt_reg - 8'h01;
        end else begin
          halfCnt_reg <= halfLimit_reg;
          config_clock_reg    <= 1'b0;
        end
      end else if (halfCnt_reg <= 8'h01) begin
        halfCnt_reg <= halfLimit_reg;
        config_clock_reg    <= !config_clock_reg;
      end else begin
        halfCnt_reg <= halfCnt_reg - 8'h01;
      end
    end
  end

  // pin outputs, all registered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      configClockOut  <= 1'b0;
      configClockOe   <= 1'b0;
      initStatusOut   <= 1'b0;
      initStatusOe    <= 1'b1;
      completionOut   <= 1'b0;
      completionOe    <= 1'b1;
      ioPullupEn      <= 1'b0;
      bytePar         <= 1'b0;
      boundaryScanSel <= 1'b0;
    end else if (clkEn) begin
      configClockOut  <= config_clock_reg;
      configClockOe   <= masterMode && state_reg != CFGLD_ST_CLEAR;
      // init pulls low during clear; it holds the PROM in reset
      initStatusOut   <= 1'b0;
      initStatusOe    <= (state_reg == CFGLD_ST_CLEAR);
      if (state_reg == CFGLD_ST_DONE && drive_reg) begin
        completionOut <= 1'b1;
        completionOe  <= 1'b1;
      end else begin
        // open drain: low until done, then released
        completionOut <= 1'b0;
        completionOe  <= (state_reg != CFGLD_ST_DONE);
      end
      ioPullupEn      <= pullup_reg && state_reg != CFGLD_ST_DONE;
      bytePar         <= (mode_reg == CFGLD_MODE_BYTEPAR);
      boundaryScanSel <= (mode_reg == CFGLD_MODE_BSCAN);
    end
  end

  // ahb slave: zero wait states, writes land in the data phase
  cfgld_status_t statusWord;
  always_comb begin
    statusWord.rateCode   = rateCode_reg;
    statusWord.completion = (state_reg == CFGLD_ST_DONE);
    statusWord.initStatus = (state_reg != CFGLD_ST_CLEAR);
    statusWord.pullupsOn  = pullup_reg;
    statusWord.mode       = mode_reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else if (clkEn) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wrPend_reg <= addrPhase && hwrite;
      wrAddr_reg <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        case (haddr[7:0])
          CFGLD_CTRL_OFS:   hrdata <= {30'h0, drive_reg, 1'b0};
          CFGLD_STATUS_OFS: hrdata <= {16'h0000, bitCnt_reg[7:0], statusWord};
          CFGLD_RATE_OFS:   hrdata <= {24'h000000, halfLimit_reg};
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register; program is a one-cycle request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_reg      <= CTRL_RESET_VAL[CTRL_DRIVE_BIT];
      programReq_reg <= CTRL_RESET_VAL[CTRL_PROGRAM_BIT];
    end else if (clkEn) begin
      programReq_reg <= 1'b0;
      if (wrPend_reg && wrAddr_reg == CFGLD_CTRL_OFS) begin
        drive_reg      <= hwdata[CTRL_DRIVE_BIT];
        programReq_reg <= hwdata[CTRL_PROGRAM_BIT];
      end
    end
  end

endmodule : cfgld_serial_loader

//--- verilog/cfgld_pkg.sv
/*
  cfgld_pkg: constants, modes and types shared by the configuration loader.
  Assumes a 200 MHz ref_clk and a 32-bit AHB-Lite register bus.
*/
package cfgld_pkg;

  // register byte offsets
  localparam logic [7:0] CFGLD_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CFGLD_STATUS_OFS = 8'h04;
  localparam logic [7:0] CFGLD_RATE_OFS   = 8'h08;

  // control register fields
  localparam int CTRL_PROGRAM_BIT = 0;  // write 1: restart configuration
  localparam int CTRL_DRIVE_BIT   = 1;  // active_completion_drive
  localparam logic [1:0] CTRL_RESET_VAL = 2'h0;

  // mode_select_pins codes, ordered MODE_SELECT_PINS; pins float high
  localparam logic [2:0] MODE_PINS_DEFAULT = 3'h7;

  typedef enum logic [1:0] {
    CFGLD_MODE_MASTER   = 2'b00,
    CFGLD_MODE_SLAVE    = 2'b01,
    CFGLD_MODE_BYTEPAR  = 2'b10,
    CFGLD_MODE_BSCAN    = 2'b11
  } cfgld_mode_t;

  typedef enum logic [1:0] {
    CFGLD_ST_CLEAR = 2'b00,
    CFGLD_ST_LOAD  = 2'b01,
    CFGLD_ST_DONE  = 2'b10,
    CFGLD_ST_HOLD  = 2'b11
  } cfgld_state_t;

  // status word carried as one packed group
  typedef struct packed {
    logic [2:0]  rateCode;
    logic        completion;
    logic        initStatus;
    logic        pullupsOn;
    cfgld_mode_t mode;
  } cfgld_status_t;

  // timing: system clock and generated config_clock rates in tenths of MHz
  localparam int unsigned REF_CLK_MHZ10  = 2000;  // 200 MHz
  localparam int unsigned POWERUP_MHZ10  = 25;    // 2.5 MHz start rate
  localparam int unsigned RATE_MHZ10 [8] = '{40, 50, 80, 100, 200, 300, 400, 600};
  localparam int unsigned CLEAR_TIME_NS  = 1000;  // memory clear phase
  localparam int unsigned REF_PERIOD_NS  = 5;
  localparam int unsigned CLEAR_CYCLES   = (CLEAR_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  // half period in ref_clk cycles, rounded up so the rate never exceeds the setting
  function automatic logic [7:0] half_cycles(input int unsigned mhz10);
    int unsigned n;
    n = (REF_CLK_MHZ10 + 2 * mhz10 - 1) / (2 * mhz10);
    return (n < 1) ? 8'h01 : 8'(n);
  endfunction : half_cycles

  localparam logic [7:0] POWERUP_HALF = half_cycles(POWERUP_MHZ10);

  // rate field inside the device's own bitstream
  localparam int RATE_POS = 8;
  localparam int RATE_W   = 3;

endpackage : cfgld_pkg

//--- bench/cfgld_serial_loader_properties.sv
/*
  Port-level checks of the configuration loader.
  Assumes it is bound to cfgld_serial_loader; mode pins stay steady over a clear phase.
*/
`timescale 1ns/1ps
module cfgld_serial_loader_properties
  import cfgld_pkg::*;
#(
  parameter int OWN_BITS = 64        // own bitstream length
) (
  input wire logic       ref_clk,         // system clock
  input wire logic       reset_n,         // async reset, active low
  input wire logic       hreadyout,       // ahb slave ready
  input wire logic       hresp,           // ahb response
  input wire logic [2:0] modeSelectPins,  // mode pins
  input wire logic       configClockIn,   // config clock line
  input wire logic       configClockOut,  // generated config clock
  input wire logic       configClockOe,   // config clock enable
  input wire logic       serialChainOut,  // chain output
  input wire logic       initStatusOut,   // init level
  input wire logic       initStatusOe,    // init pull enable
  input wire logic       completionOut,   // completion level
  input wire logic       completionOe,    // completion enable
  input wire logic       ioPullupEn,      // i/o pull-ups
  input wire logic       bytePar,         // byte-parallel selected
  input wire logic       boundaryScanSel  // boundary scan selected
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // clear phase: init pulled low, then let go after the fixed clear time
  sequence clearStarts;
    $rose(initStatusOe) ##1 initStatusOe [*8];
  endsequence
  sequence clearEnds;
    $fell(initStatusOe);
  endsequence

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_BSCAN_DECODE: assert property (clearEnds |->
    boundaryScanSel == ($past(modeSelectPins, 8) inside {3'h5, 3'h1}))
    else $error("boundary scan decode wrong");
  AST_BYTEPAR_DECODE: assert property (clearEnds |->
    bytePar == ($past(modeSelectPins, 8) inside {3'h6, 3'h2}))
    else $error("byte-parallel decode wrong");
  AST_CLK_MODE: assert property (configClockOe |-> !bytePar && !boundaryScanSel)
    else $error("clock driven in a non-serial mode");
  AST_CLK_HIGH: assert property ($rose(configClockOut) |-> configClockOut [*2])
    else $error("generated clock high phase too short");
  AST_CHAIN_EDGE: assert property ($changed(serialChainOut) |->
    ##1 (configClockIn || configClockOut || initStatusOe))
    else $error("chain output moved away from a clock rise");
  AST_CLEAR_LEN: assert property (clearStarts |-> ##[180:200] !initStatusOe)
    else $error("clear phase length wrong");
  AST_DONE_AFTER_INIT: assert property (initStatusOe [*2] |-> completionOe && !completionOut)
    else $error("completion released during clear");
  AST_PULLUP_PRECONFIG: assert property (ioPullupEn |-> completionOe && !completionOut)
    else $error("pull-ups on after completion");
  AST_INIT_OD: assert property (initStatusOut == 1'b0)
    else $error("init driven high");
endmodule : cfgld_serial_loader_properties

bind cfgld_serial_loader cfgld_serial_loader_properties #(.OWN_BITS(OWN_BITS)) props_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
  .modeSelectPins(modeSelectPins), .configClockIn(configClockIn),
  .configClockOut(configClockOut), .configClockOe(configClockOe),
  .serialChainOut(serialChainOut), .initStatusOut(initStatusOut),
  .initStatusOe(initStatusOe), .completionOut(completionOut), .completionOe(completionOe),
  .ioPullupEn(ioPullupEn), .bytePar(bytePar), .boundaryScanSel(boundaryScanSel));

//--- bench/cfgld_source_model.sv
/*
  Serial PROM or upstream chain device feeding the loader.
  Assumes the bench resolves the config clock line and the init and completion levels.
*/
`timescale 1ns/1ps
module cfgld_source_model (
  input  wire logic        start,     // begin one frame
  input  wire logic        master,    // follow the device clock
  input  wire logic        initHigh,  // init line level
  input  wire logic        ceN,       // chip enable, low active
  input  wire logic        cfgClk,    // config clock line
  input  wire logic        chainIn,   // chain output of device
  input  wire logic [31:0] pattern,   // bits, first at msb
  input  wire logic [5:0]  nBits,     // bits in frame
  output logic             slaveClk,  // clock made in slave mode
  output logic             dataOut,   // serial data line
  output logic      [31:0] rx,        // chain bits seen at rises
  output logic             busy       // frame running
);
  int i;

  // one frame per start; clock stands still between frames
  initial begin
    slaveClk = 1'b0;
    dataOut = 1'b1;
    rx = '0;
    busy = 1'b0;
    forever begin
      @(posedge start);
      busy = 1'b1;
      wait (initHigh);
      #1; // step off the ref_clk edge that released init
      for (i = 0; i < nBits && !ceN; i++) begin
        dataOut = pattern[31-i];
        if (master) @(posedge cfgClk);
        else #62.5 slaveClk = 1'b1;
        rx = {rx[30:0], chainIn};
        if (master) #1;
        else #62.5 slaveClk = 1'b0;
      end
      // released line must not keep showing the last bit
      dataOut = ~dataOut;
      busy = 1'b0;
    end
  end
endmodule : cfgld_source_model

//--- bench/tb.sv
/*
  Self-checking bench: reset, mode decode, slave load with chaining, master loads.
  Assumes cfgld_source_model on the serial side and the bound property checker.
*/
`timescale 1ns/1ps
module tb;
  import cfgld_pkg::*;
  logic        ref_clk, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0;
  logic        master = 1'b0, hreadyout, hresp, cfgOut, cfgOe, slaveClk, dIn, chain;
  logic        initOut, initOe, compOut, compOe, pull, bytePar, bscan, busy;
  logic [31:0] haddr = '0, hwdata = '0, pattern = '0, hrdata, rd, rx;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  pins = 3'h7;
  logic [5:0]  nBits = 6'h0;
  int          errors = 0, checks = 0;
  wire logic   cfgClk = cfgOe ? cfgOut : slaveClk;
  wire logic   compLvl = compOe ? compOut : 1'b1;

  cfgld_serial_loader #(.OWN_BITS(16)) cfgld_serial_loader_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .modeSelectPins(pins),
    .configClockIn(cfgClk), .configClockOut(cfgOut), .configClockOe(cfgOe),
    .serialDataIn(dIn), .serialChainOut(chain), .initStatusOut(initOut),
    .initStatusOe(initOe), .completionOut(compOut), .completionOe(compOe),
    .ioPullupEn(pull), .bytePar(bytePar), .boundaryScanSel(bscan));
  cfgld_source_model cfgld_source_model_i (
    .start(start), .master(master), .initHigh(!initOe), .ceN(master && compLvl),
    .cfgClk(cfgClk), .chainIn(chain), .pattern(pattern), .nBits(nBits),
    .slaveClk(slaveClk), .dataOut(dIn), .rx(rx), .busy(busy));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single ahb transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // bounded wait; a miss counts as a mismatch
  task automatic wait_sig(ref logic s, input logic lvl, input int lim);
    for (int n = 0; n < lim && s !== lvl; n++) @(posedge ref_clk);
    chk(32'(s), 32'(lvl));
  endtask : wait_sig

  // new pins, program pulse, optional source start while init is low
  task automatic restart(input logic [2:0] code, input logic drv, input logic go);
    pins <= code;
    ahb(1'b1, CFGLD_CTRL_OFS, {30'h0, drv, 1'b1});
    wait_sig(initOe, 1'b1, 20);
    start <= go;
    wait_sig(initOe, 1'b0, 400);
    start <= 1'b0;
  endtask : restart

  task automatic t_reset;
    repeat (20) @(posedge ref_clk);
    chk({initOe, compOe, cfgOe, chain}, 4'hd);
    reset_n <= 1'b1;
    wait_sig(initOe, 1'b0, 400);
    ahb(1'b0, CFGLD_STATUS_OFS, 32'h0);
    chk(rd[4:0], 5'h09);
    ahb(1'b0, CFGLD_RATE_OFS, 32'h0);
    chk(rd, 32'h28);
    ahb(1'b0, CFGLD_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_modes;
    logic [2:0] c;
    logic [1:0] m;
    logic       p;
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      m = (c[1:0] == 2'h0) ? 2'h0 : 2'(3'h4 - {1'b0, c[1:0]});
      p = c[2] ^ (c[1:0] != 2'h0);
      restart(c, 1'b0, 1'b0);
      ahb(1'b0, CFGLD_STATUS_OFS, 32'h0);
      chk(rd[2:0], {p, m});
      chk({bytePar, bscan, pull}, {m == 2'h2, m == 2'h3, p});
    end
  endtask : t_modes

  // 16 own bits, then 9 more so the 8 forwarded bits reach the source
  task automatic t_slave;
    nBits <= 6'd25;
    pattern <= 32'hc3a5_5a00;
    restart(3'h7, 1'b0, 1'b1);
    wait_sig(busy, 1'b0, 2000);
    ahb(1'b0, CFGLD_STATUS_OFS, 32'h0);
    chk(rd[4], 1'b1);
    chk(rd[15:8], 8'h10);
    chk(compOe, 1'b0);
    chk(rx[7:0], 8'h5a);
  endtask : t_slave

  task automatic t_master(input logic [2:0] code, input logic [31:0] half);
    master <= 1'b1;
    nBits <= 6'd16;
    pattern <= {8'h96, code, 21'h0};
    restart(3'h0, 1'b1, 1'b1);
    ahb(1'b0, CFGLD_RATE_OFS, 32'h0);
    chk(rd, 32'h28);
    chk(cfgOe, 1'b1);
    wait_sig(busy, 1'b0, 3000);
    ahb(1'b0, CFGLD_STATUS_OFS, 32'h0);
    chk(rd[7:4], {code, 1'b1});
    ahb(1'b0, CFGLD_RATE_OFS, 32'h0);
    chk(rd, half);
    chk({compOe, compOut}, 2'h3);
  endtask : t_master

  // hang guard, far beyond the roughly 26 us the sequence needs
  initial begin
    #150us;
    errors++;
    $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  end

  initial begin
    t_reset();
    t_modes();
    t_slave();
    t_master(3'h0, 32'h19);
    t_master(3'h7, 32'h02);
    complete_run();
  end
endmodule : tb
